// ===== rtl/pdfs_top.sv
/*
 * Port D pin-function selector for pins 22 to 8: mode registers,
 * register port and registered pin steering.
 * Assumes one clock mclk, synchronous reset rst, pin levels from
 * outside the clock domain and owner signals on mclk.
 */
`timescale 1ns/1ps
`include "pdfs_regs.svh"

// What this block does
// - Pin 22 owner from high2 bits 13:12
// - Pin 21 owner from high2 bits 11:10
// - Pin 20 owner from high2 bits 9:8
// - Pin 19 owner from high2 bits 7:6
// - Pin 18 owner from high2 bits 5:4
// - Pin 17 owner from high2 bits 3:2
// - Pin 16 owner from high2 bits 1:0
// - Pin 15 port or bus, low2/low1 bit 15
// - Pin 14 port or bus, bit 14
// - Pin 13 port or bus, bit 13
// - Pin 12 port or bus, bit 12
// - Pin 11 port or bus, bit 11
// - Pin 10 port or bus, bit 10
// - Pin 9 port or bus, bit 9
// - Pin 8 port or bus, bit 8
// - Expansion boot resets pins 15-8 to bus
// - 32-bit expansion boot resets pins 22-16 to bus
module pdfs_top (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Boot straps from pins
  input  wire logic         strap_rom_off_ext,
  input  wire logic         strap_ext32,
  // Register port
  input  wire logic [3:0]   addr,
  input  wire logic [15:0]  wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic      [15:0]  rdata,
  // Pads
  input  wire logic [22:8]  pin_in,
  output logic      [22:8]  pin_out,
  output logic      [22:8]  pin_oe,
  // Port data and direction registers
  input  wire logic [22:8]  port_dout,
  input  wire logic [22:8]  port_dir,
  output logic      [22:8]  port_din,
  // External bus controller
  input  wire logic [22:8]  bus_dout,
  input  wire logic         bus_oe,
  output logic      [22:8]  bus_din,
  // Interrupt controller
  output logic      [6:0]   ext_interrupt_in,
  // Debug trace unit
  input  wire logic [3:0]   trace_dout,
  input  wire logic [3:0]   trace_data_oe,
  input  wire logic         trace_clock_out,
  input  wire logic         trace_clock_oe,
  output logic      [3:0]   trace_data_in,
  output logic              trace_clock_in,
  output logic              trace_mode_in,
  output logic              trace_reset_in
);

  // ****************************************************************
  // State
  // ****************************************************************

  pdfs_pkg::pdfs_state_t cur;
  pdfs_pkg::pdfs_state_t next_cur;

  // Per-pin mode codes and steered results
  pdfs_pkg::pdfs_mode_t mode_w [`PDFS_PIN_TOP:`PDFS_PIN_BOT];
  logic [`PDFS_PIN_TOP:`PDFS_PIN_BOT] c_do;
  logic [`PDFS_PIN_TOP:`PDFS_PIN_BOT] c_oe;
  logic [`PDFS_PIN_TOP:`PDFS_PIN_BOT] c_port;
  logic [`PDFS_PIN_TOP:`PDFS_PIN_BOT] c_bus;
  logic [`PDFS_PIN_TOP:`PDFS_PIN_BOT] c_irq;
  logic [`PDFS_PIN_TOP:`PDFS_PIN_BOT] c_alt;
  logic [`PDFS_PIN_TOP:`PDFS_PIN_BOT] alt_do;
  logic [`PDFS_PIN_TOP:`PDFS_PIN_BOT] alt_oe;

  // ****************************************************************
  // Alternate owner drive
  // ****************************************************************

  // Trace clock and data may drive; mode and reset are inputs only
  always_comb begin
    alt_do = '0;
    alt_oe = '0;
    alt_do[`PDFS_PIN_TCLK] = trace_clock_out;
    alt_oe[`PDFS_PIN_TCLK] = trace_clock_oe;
    alt_do[`PDFS_PIN_TDAT:`PDFS_HI_BASE] = trace_dout;
    alt_oe[`PDFS_PIN_TDAT:`PDFS_HI_BASE] = trace_data_oe;
  end

  // ****************************************************************
  // Pin cells
  // ****************************************************************

  // Upper pins take both bits from high2, lower pins one from each half
  genvar p;
  generate
    for (p = `PDFS_PIN_BOT; p <= `PDFS_PIN_TOP; p++) begin : g_pin
      if (p >= `PDFS_HI_BASE) begin : g_hi
        assign mode_w[p] = pdfs_pkg::pdfs_mode_t'(
          cur.high2[2*(p-`PDFS_HI_BASE)+1 -: 2]);
      end else begin : g_lo
        assign mode_w[p] = pdfs_pkg::pdfs_mode_t'({cur.low2[p], cur.low1[p]});
      end
      pdfs_pin_cell #(
        .HAS_ALT (p >= `PDFS_HI_BASE),
        .ALT_OUT (p != `PDFS_PIN_TMODE && p != `PDFS_PIN_TRST)
      ) u_cell (
        .mode     (mode_w[p]),
        .pin_in   (cur.pin_s2[p]),
        .port_do  (port_dout[p]),
        .port_dir (port_dir[p]),
        .bus_do   (bus_dout[p]),
        .bus_oe   (bus_oe),
        .alt_do   (alt_do[p]),
        .alt_oe   (alt_oe[p]),
        .pin_do   (c_do[p]),
        .pin_oe   (c_oe[p]),
        .port_di  (c_port[p]),
        .bus_di   (c_bus[p]),
        .irq_di   (c_irq[p]),
        .alt_di   (c_alt[p])
      );
    end
  endgenerate

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Synchronisers, register port, steering and reset
  always_comb begin
    next_cur = cur;
    // Two-stage capture of pin levels and straps
    next_cur.pin_s1   = pin_in;
    next_cur.pin_s2   = cur.pin_s1;
    next_cur.strap_s1 = {strap_ext32, strap_rom_off_ext};
    next_cur.strap_s2 = cur.strap_s1;
    // Read data stand only in the cycle after the strobe
    next_cur.rdata = `PDFS_RD_IDLE;
    if (rd) begin
      unique case (addr)
        `PDFS_OFS_HIGH2: next_cur.rdata = {`PDFS_RSVD_HI2, cur.high2};
        `PDFS_OFS_LOW2:  next_cur.rdata = {cur.low2, `PDFS_RSVD_BYTE};
        `PDFS_OFS_LOW1:  next_cur.rdata = {cur.low1, `PDFS_RSVD_BYTE};
        default:         next_cur.rdata = `PDFS_RD_IDLE;
      endcase
    end
    // Writes land at the strobe edge
    if (wr) begin
      unique case (addr)
        `PDFS_OFS_HIGH2: next_cur.high2 = wdata[`PDFS_HI2_TOP:0];
        `PDFS_OFS_LOW2:  next_cur.low2 = wdata[`PDFS_LOW_TOP:`PDFS_PIN_BOT];
        `PDFS_OFS_LOW1:  next_cur.low1 = wdata[`PDFS_LOW_TOP:`PDFS_PIN_BOT];
        default:         next_cur.high2 = cur.high2;
      endcase
    end
    // Registered pin steering
    next_cur.pin_out  = c_do;
    next_cur.pin_oe   = c_oe;
    next_cur.port_din = c_port;
    next_cur.bus_din  = c_bus;
    next_cur.irq      = c_irq[`PDFS_PIN_TOP:`PDFS_HI_BASE];
    next_cur.tclk     = c_alt[`PDFS_PIN_TCLK];
    next_cur.tmode    = c_alt[`PDFS_PIN_TMODE];
    next_cur.trst     = c_alt[`PDFS_PIN_TRST];
    next_cur.tdata    = c_alt[`PDFS_PIN_TDAT:`PDFS_HI_BASE];
    // Reset: straps choose bus ownership of the data pins
    if (rst) begin
      next_cur.rdata    = `PDFS_RD_IDLE;
      next_cur.low2     = `PDFS_RST_LOW;
      next_cur.low1     = cur.strap_s2[`PDFS_STRAP_EXT] ?
                          `PDFS_LOW_ONES : `PDFS_RST_LOW;
      next_cur.high2    = (cur.strap_s2[`PDFS_STRAP_EXT] &&
                           cur.strap_s2[`PDFS_STRAP_W32]) ?
                          `PDFS_HI2_LO_MASK : `PDFS_RST_HI2;
      next_cur.pin_out  = '0;
      next_cur.pin_oe   = '0;
      next_cur.port_din = '0;
      next_cur.bus_din  = '0;
      next_cur.irq      = '0;
      next_cur.tdata    = '0;
      next_cur.tclk     = 1'b0;
      next_cur.tmode    = 1'b0;
      next_cur.trst     = 1'b0;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    cur <= next_cur;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // All straight from state flip-flops
  assign rdata            = cur.rdata;
  assign pin_out          = cur.pin_out;
  assign pin_oe           = cur.pin_oe;
  assign port_din         = cur.port_din;
  assign bus_din          = cur.bus_din;
  assign ext_interrupt_in = cur.irq;
  assign trace_data_in    = cur.tdata;
  assign trace_clock_in   = cur.tclk;
  assign trace_mode_in    = cur.tmode;
  assign trace_reset_in   = cur.trst;

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_pin22_trace_clk:
    assert property (mode_w[22] == pdfs_pkg::PDFS_TRACE |=>
      pin_out[22] == $past(trace_clock_out) && pin_oe[22] == $past(trace_clock_oe))
    else $error("pin 22 not driven by trace clock");

  chk_pin21_ext_interrupt_5_in:
    assert property (mode_w[21] == pdfs_pkg::PDFS_IRQ |=>
      ext_interrupt_in[5] == $past(cur.pin_s2[21]) && !pin_oe[21])
    else $error("pin 21 not routed to interrupt 5");

  chk_pin20_trace_rst:
    assert property (mode_w[20] == pdfs_pkg::PDFS_TRACE |=>
      trace_reset_in == $past(cur.pin_s2[20]) && !pin_oe[20])
    else $error("pin 20 not routed to trace reset");

  chk_pin19_bus_data:
    assert property (mode_w[19] == pdfs_pkg::PDFS_BUS |=>
      bus_din[19] == $past(cur.pin_s2[19]) && pin_oe[19] == $past(bus_oe))
    else $error("pin 19 not routed to bus");

  chk_pin18_port_io:
    assert property (mode_w[18] == pdfs_pkg::PDFS_PORT |=>
      pin_oe[18] == $past(port_dir[18]) && pin_out[18] == $past(port_dout[18]))
    else $error("pin 18 not under port control");

  chk_pin17_trace_dat:
    assert property (mode_w[17] == pdfs_pkg::PDFS_TRACE |=>
      trace_data_in[1] == $past(cur.pin_s2[17]) &&
      pin_oe[17] == $past(trace_data_oe[1]))
    else $error("pin 17 not routed to trace data 1");

  chk_pin16_irq_lat:
    assert property (mode_w[16] == pdfs_pkg::PDFS_IRQ [*3] |->
      ext_interrupt_in[0] == $past(pin_in[16], 3))
    else $error("pin 16 interrupt path latency wrong");

  chk_pin15_bus:
    assert property ({cur.low2[15], cur.low1[15]} == 2'h1 |=>
      pin_out[15] == $past(bus_dout[15]) && pin_oe[15] == $past(bus_oe))
    else $error("pin 15 not driven by bus");

  chk_pin14_port:
    assert property (mode_w[14] == pdfs_pkg::PDFS_PORT |=>
      port_din[14] == $past(cur.pin_s2[14]) && bus_din[14] == 1'b0)
    else $error("pin 14 port input wrong");

  chk_pin13_bus_drv:
    assert property (mode_w[13] == pdfs_pkg::PDFS_BUS |=>
      pin_out[13] == $past(bus_dout[13]) && pin_oe[13] == $past(bus_oe))
    else $error("pin 13 not driven by bus");

  chk_pin12_bus_in:
    assert property (mode_w[12] == pdfs_pkg::PDFS_BUS |=>
      bus_din[12] == $past(cur.pin_s2[12]) && port_din[12] == 1'b0)
    else $error("pin 12 bus input wrong");

  chk_pin11_port_in:
    assert property (mode_w[11] == pdfs_pkg::PDFS_PORT |=>
      port_din[11] == $past(cur.pin_s2[11]) && bus_din[11] == 1'b0)
    else $error("pin 11 port input wrong");

  chk_pin10_port_out:
    assert property (mode_w[10] == pdfs_pkg::PDFS_PORT |=>
      pin_out[10] == $past(port_dout[10]))
    else $error("pin 10 port output wrong");

  chk_pin9_bus_oe:
    assert property (mode_w[9] == pdfs_pkg::PDFS_BUS |=>
      pin_oe[9] == $past(bus_oe))
    else $error("pin 9 bus enable wrong");

  chk_pin8_bus_out:
    assert property (mode_w[8] == pdfs_pkg::PDFS_BUS |=>
      pin_out[8] == $past(bus_dout[8]))
    else $error("pin 8 bus output wrong");

  chk_low_boot_mode:
    assert property ($fell(rst) |->
      cur.low1 == ($past(cur.strap_s2[0]) ? 8'hFF : 8'h00) && cur.low2 == 8'h00)
    else $error("low mode bits wrong after reset");

  chk_high_boot_mode:
    assert property ($fell(rst) |->
      cur.high2 == (&$past(cur.strap_s2) ? 14'h1555 : 14'h0000))
    else $error("high mode bits wrong after reset");

  chk_write_readback:
    assert property (wr && addr == `PDFS_OFS_HIGH2 ##1 rd && addr == `PDFS_OFS_HIGH2
      |=> rdata == {2'h0, $past(wdata[13:0], 2)})
    else $error("high2 write not read back");

  // A write lands in the mode register at its own strobe edge
  chk_high_write_land:
    assert property (wr && addr == `PDFS_OFS_HIGH2 |=>
      cur.high2 == $past(wdata[`PDFS_HI2_TOP:0]))
    else $error("high2 write did not land");

  chk_read_one_cycle:
    assert property (!rd |=> rdata == 16'h0000)
    else $error("read data outside answer cycle");

  chk_port_dir_only:
    assert property (mode_w[22] == pdfs_pkg::PDFS_PORT |=>
      pin_oe[22] == $past(port_dir[22]))
    else $error("port direction not applied");

  cov_trace_clock:
    cover property (mode_w[22] == pdfs_pkg::PDFS_TRACE ##1 pin_oe[22]);
  cov_irq_edge:
    cover property (mode_w[16] == pdfs_pkg::PDFS_IRQ ##1 $rose(ext_interrupt_in[0]));
  cov_low_bus:
    cover property (mode_w[15] == pdfs_pkg::PDFS_BUS ##1 pin_oe[15]);
  cov_b2b_readback:
    cover property (wr ##1 rd);

endmodule

// ===== rtl/pdfs_regs.svh
/*
 * Register offsets, field positions and reset values of the port D
 * pin-function selector.
 * Assumes a 4-bit register address and 16-bit register data.
 */
`ifndef PDFS_REGS_SVH
`define PDFS_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PDFS_OFS_HIGH2   4'h0
`define PDFS_OFS_LOW2    4'h2
`define PDFS_OFS_LOW1    4'h4

// ****************************************************************
// Pin ranges and field positions
// ****************************************************************
`define PDFS_PIN_TOP     22
`define PDFS_PIN_BOT     8
`define PDFS_HI_BASE     16
`define PDFS_LOW_TOP     15
`define PDFS_HI2_TOP     13
`define PDFS_IRQ_TOP     6
`define PDFS_TDAT_TOP    3
`define PDFS_PIN_TCLK    22
`define PDFS_PIN_TMODE   21
`define PDFS_PIN_TRST    20
`define PDFS_PIN_TDAT    19
`define PDFS_STRAP_EXT   0
`define PDFS_STRAP_W32   1

// ****************************************************************
// Reset values
// ****************************************************************
`define PDFS_RST_HI2     14'h0000
`define PDFS_HI2_LO_MASK 14'h1555
`define PDFS_RST_LOW     8'h00
`define PDFS_LOW_ONES    8'hFF
`define PDFS_RD_IDLE     16'h0000
`define PDFS_RSVD_BYTE   8'h00
`define PDFS_RSVD_HI2    2'h0

`endif

// ===== rtl/pdfs_pkg.sv
/*
 * Types of the port D pin-function selector: mode codes and the
 * packed state of the top module.
 * Assumes pdfs_regs.svh is on the include path.
 */
`include "pdfs_regs.svh"

package pdfs_pkg;

  // ****************************************************************
  // Pin owner codes
  // ****************************************************************
  typedef enum logic [1:0] {
    PDFS_PORT  = 2'h0,
    PDFS_BUS   = 2'h1,
    PDFS_IRQ   = 2'h2,
    PDFS_TRACE = 2'h3
  } pdfs_mode_t;

  // ****************************************************************
  // Whole state of the top module
  // ****************************************************************
  typedef struct packed {
    logic [`PDFS_HI2_TOP:0]               high2;
    logic [`PDFS_LOW_TOP:`PDFS_PIN_BOT]   low2;
    logic [`PDFS_LOW_TOP:`PDFS_PIN_BOT]   low1;
    logic [15:0]                          rdata;
    logic [`PDFS_PIN_TOP:`PDFS_PIN_BOT]   pin_s1;
    logic [`PDFS_PIN_TOP:`PDFS_PIN_BOT]   pin_s2;
    logic [1:0]                           strap_s1;
    logic [1:0]                           strap_s2;
    logic [`PDFS_PIN_TOP:`PDFS_PIN_BOT]   pin_out;
    logic [`PDFS_PIN_TOP:`PDFS_PIN_BOT]   pin_oe;
    logic [`PDFS_PIN_TOP:`PDFS_PIN_BOT]   port_din;
    logic [`PDFS_PIN_TOP:`PDFS_PIN_BOT]   bus_din;
    logic [`PDFS_IRQ_TOP:0]               irq;
    logic [`PDFS_TDAT_TOP:0]              tdata;
    logic                                 tclk;
    logic                                 tmode;
    logic                                 trst;
  } pdfs_state_t;

endpackage

// ===== rtl/pdfs_pin_cell.sv
/*
 * One pin of port D: steers pin drive and pin level between the
 * port, the external bus, the interrupt input and one alternate owner by a 2-bit code.
 * Assumes all inputs are on mclk; purely combinational.
 */
`timescale 1ns/1ps

module pdfs_pin_cell #(
  parameter bit HAS_ALT = 1'b1,
  parameter bit ALT_OUT = 1'b1
) (
  // Selection
  input  wire pdfs_pkg::pdfs_mode_t mode,
  // Pin level, already synchronised
  input  wire logic                 pin_in,
  // Owner drives
  input  wire logic                 port_do,
  input  wire logic                 port_dir,
  input  wire logic                 bus_do,
  input  wire logic                 bus_oe,
  input  wire logic                 alt_do,
  input  wire logic                 alt_oe,
  // Steered results
  output logic                      pin_do,
  output logic                      pin_oe,
  output logic                      port_di,
  output logic                      bus_di,
  output logic                      irq_di,
  output logic                      alt_di
);

  // ****************************************************************
  // Owner steering
  // ****************************************************************

  // Codes without an alternate owner fall back to the port
  always_comb begin
    pin_do  = port_do;
    pin_oe  = port_dir;
    port_di = 1'b0;
    bus_di  = 1'b0;
    irq_di  = 1'b0;
    alt_di  = 1'b0;
    unique case (mode)
      pdfs_pkg::PDFS_BUS: begin
        pin_do = bus_do;
        pin_oe = bus_oe;
        bus_di = pin_in;
      end
      pdfs_pkg::PDFS_IRQ: begin
        if (HAS_ALT) begin
          pin_do = 1'b0;
          pin_oe = 1'b0;
          irq_di = pin_in;
        end else begin
          port_di = pin_in;
        end
      end
      pdfs_pkg::PDFS_TRACE: begin
        if (HAS_ALT) begin
          pin_do = ALT_OUT ? alt_do : 1'b0;
          pin_oe = ALT_OUT ? alt_oe : 1'b0;
          alt_di = pin_in;
        end else begin
          port_di = pin_in;
        end
      end
      pdfs_pkg::PDFS_PORT: begin
        port_di = pin_in;
      end
    endcase
  end

endmodule

// ===== testbench/pdfs_pad_model.sv
/*
 * Far side of the port D pads: external bus devices, interrupt sources
 * and trace tools, reduced to one outside driver per pad.
 * Assumes the bench releases a pad whenever the block may drive it;
 * released pads rest at the board pull-up level.
 */
`timescale 1ns/1ps

module pdfs_pad_model (
  // Block side of the pads
  input  wire logic [22:8] pin_out,
  input  wire logic [22:8] pin_oe,
  // Outside drivers
  input  wire logic [22:8] ext_drive,
  input  wire logic [22:8] ext_level,
  // Level seen at the pads
  output logic      [22:8] pin_in
);
  // ****************************************************************
  // Pad resolution
  // ****************************************************************
  // Block drive first, then outside driver, else pull-up high
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_level) |
                  (~pin_oe & ~ext_drive);
endmodule

// ===== testbench/testbench.sv
/*
 * Self-checking bench of the port D pin-function selector: register
 * access, reset values per boot strap, and pin steering per owner code.
 * Assumes pdfs_regs.svh on the include path and the pad model beside it.
 */
`timescale 1ns/1ps
`include "pdfs_regs.svh"

`define CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end

module testbench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        mclk, rst, strap_rom_off_ext, strap_ext32;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata;
  logic        wr, rd, bus_oe;
  logic [22:8] pin_in, pin_out, pin_oe, port_dout, port_dir, port_din;
  logic [22:8] bus_dout, bus_din, ext_drive, ext_level;
  logic [6:0]  ext_interrupt_in;
  logic [3:0]  trace_dout, trace_data_oe, trace_data_in;
  logic        trace_clock_out, trace_clock_oe, trace_clock_in;
  logic        trace_mode_in, trace_reset_in;
  int          n_mismatch, cmp_count;

  pdfs_top pdfs_top_i (.mclk(mclk), .rst(rst), .strap_rom_off_ext(strap_rom_off_ext),
    .strap_ext32(strap_ext32), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .port_dout(port_dout), .port_dir(port_dir), .port_din(port_din),
    .bus_dout(bus_dout), .bus_oe(bus_oe), .bus_din(bus_din),
    .ext_interrupt_in(ext_interrupt_in), .trace_dout(trace_dout),
    .trace_data_oe(trace_data_oe), .trace_clock_out(trace_clock_out),
    .trace_clock_oe(trace_clock_oe), .trace_data_in(trace_data_in),
    .trace_clock_in(trace_clock_in), .trace_mode_in(trace_mode_in),
    .trace_reset_in(trace_reset_in));

  pdfs_pad_model pdfs_pad_model_i (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_drive(ext_drive), .ext_level(ext_level), .pin_in(pin_in));

  // Free-running 125 MHz clock
  always #4 mclk = ~mclk;

  // ****************************************************************
  // Bus and reset tasks
  // ****************************************************************
  // One-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  // One-cycle read strobe, data compared in the following cycle
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  // Reset held long enough for the strap synchronisers
  task automatic do_reset(input logic rom_off, input logic w32);
    @(posedge mclk);
    strap_rom_off_ext <= rom_off;
    strap_ext32       <= w32;
    rst               <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
  endtask

  // Owner code of a pin for a common high code and low bus choice
  function automatic logic [1:0] mode_of(input int p, input logic [1:0] c, input logic b);
    return (p >= 16) ? c : {1'b0, b};
  endfunction

  // ****************************************************************
  // Routing checks
  // ****************************************************************
  // Pad levels steered to the selected owner only
  task automatic in_chk(input logic [1:0] c, input logic b, input logic [22:8] lvl);
    logic [22:8] ep;
    logic [22:8] eb;
    logic [6:0]  ei;
    logic [3:0]  et;
    @(posedge mclk);
    ext_level <= lvl;
    repeat (5) @(posedge mclk);
    #1;
    for (int p = 8; p <= 22; p++) begin
      ep[p] = (mode_of(p, c, b) == 2'h0) & lvl[p];
      eb[p] = (mode_of(p, c, b) == 2'h1) & lvl[p];
    end
    for (int k = 0; k < 7; k++) ei[k] = (c == 2'h2) & lvl[16+k];
    for (int k = 0; k < 4; k++) et[k] = (c == 2'h3) & lvl[16+k];
    `CHK(port_din, ep)
    `CHK(bus_din, eb)
    `CHK(ext_interrupt_in, ei)
    `CHK(trace_data_in, et)
    `CHK(trace_clock_in, (c == 2'h3) & lvl[22])
    `CHK(trace_mode_in, (c == 2'h3) & lvl[21])
    `CHK(trace_reset_in, (c == 2'h3) & lvl[20])
  endtask

  // Pad drive from the selected owner, then pad levels inward
  task automatic route(input logic [1:0] c, input logic b);
    logic [22:8] eoe;
    logic [22:8] eout;
    logic [1:0]  m;
    @(posedge mclk);
    port_dir        <= 15'h4F35;
    port_dout       <= 15'h2A5C;
    bus_oe          <= 1'b1;
    bus_dout        <= 15'h55A3;
    trace_data_oe   <= 4'h6;
    trace_dout      <= 4'hC;
    trace_clock_oe  <= 1'b1;
    trace_clock_out <= 1'b1;
    ext_drive       <= 15'h0000;
    wr_reg(`PDFS_OFS_HIGH2, {2'h0, {7{c}}});
    wr_reg(`PDFS_OFS_LOW1, b ? 16'hFF00 : 16'h0000);
    repeat (2) @(posedge mclk);
    #1;
    for (int p = 8; p <= 22; p++) begin
      m = mode_of(p, c, b);
      eoe[p] = (m == 2'h0) ? port_dir[p] : (m == 2'h1) ? bus_oe :
               (m == 2'h3 && p < 20) ? trace_data_oe[p-16] :
               (m == 2'h3 && p == 22) ? trace_clock_oe : 1'b0;
      eout[p] = (m == 2'h0) ? port_dout[p] : (m == 2'h1) ? bus_dout[p] :
                (m == 2'h3 && p < 20) ? trace_dout[p-16] :
                (m == 2'h3 && p == 22) ? trace_clock_out : 1'b0;
    end
    `CHK(pin_oe, eoe)
    `CHK(pin_out & pin_oe, eout & eoe)
    @(posedge mclk);
    port_dir       <= 15'h0000;
    bus_oe         <= 1'b0;
    trace_data_oe  <= 4'h0;
    trace_clock_oe <= 1'b0;
    ext_drive      <= 15'h7FFF;
    in_chk(c, b, 15'h3CA5);
    in_chk(c, b, 15'h435A);
  endtask

  // ****************************************************************
  // Verdict
  // ****************************************************************
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cut a hung run short
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    $display("ERROR %0t: run did not complete", $time);
    finish_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    mclk = 1'b0; rst = 1'b1; strap_rom_off_ext = 1'b0; strap_ext32 = 1'b0;
    addr = 4'h0; wdata = 16'h0000; wr = 1'b0; rd = 1'b0;
    port_dout = 15'h0000; port_dir = 15'h0000; bus_dout = 15'h0000; bus_oe = 1'b0;
    trace_dout = 4'h0; trace_data_oe = 4'h0; trace_clock_out = 1'b0;
    trace_clock_oe = 1'b0; ext_drive = 15'h0000; ext_level = 15'h0000;
    n_mismatch = 0; cmp_count = 0;
    do_reset(1'b0, 1'b0);
    rd_chk(`PDFS_OFS_HIGH2, 16'h0000);
    rd_chk(`PDFS_OFS_LOW1, 16'h0000);
    rd_chk(`PDFS_OFS_LOW2, 16'h0000);
    @(posedge mclk);
    #1;
    `CHK(rdata, 16'h0000)
    // Read back, reserved bits and an unmapped place
    wr_reg(`PDFS_OFS_HIGH2, 16'hFFFF);
    rd_chk(`PDFS_OFS_HIGH2, 16'h3FFF);
    wr_reg(`PDFS_OFS_LOW2, 16'h00FF);
    rd_chk(`PDFS_OFS_LOW2, 16'h0000);
    wr_reg(`PDFS_OFS_LOW1, 16'hFFFF);
    rd_chk(`PDFS_OFS_LOW1, 16'hFF00);
    wr_reg(4'h6, 16'hFFFF);
    rd_chk(4'h6, 16'h0000);
    rd_chk(`PDFS_OFS_HIGH2, 16'h3FFF);
    wr_reg(`PDFS_OFS_HIGH2, 16'h1B6C);
    rd_chk(`PDFS_OFS_HIGH2, 16'h1B6C);
    // Write then read with no gap between the strobes
    @(posedge mclk);
    addr  <= `PDFS_OFS_HIGH2;
    wdata <= 16'h2D4B;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, 16'h2D4B)
    // Every owner code on the upper pins, both codes on the lower pins
    for (int c = 0; c < 4; c++) route(2'(c), c[0]);
    // Boot straps select bus mode at reset, also in mid-run
    do_reset(1'b1, 1'b0);
    rd_chk(`PDFS_OFS_HIGH2, 16'h0000);
    rd_chk(`PDFS_OFS_LOW1, 16'hFF00);
    do_reset(1'b1, 1'b1);
    rd_chk(`PDFS_OFS_HIGH2, 16'h1555);
    rd_chk(`PDFS_OFS_LOW1, 16'hFF00);
    rd_chk(`PDFS_OFS_LOW2, 16'h0000);
    finish_test();
  end
endmodule
